// [src/doau_data_ram.sv]
// Purpose: Data storage array, one write and one registered read port
// Assumes: Single clock, synchronous reset only clears read data
// Notes:   Array contents are not reset
`timescale 1ns/1ps
`default_nettype none
module doau_data_ram #(
  parameter int WORDS = 256,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port
  input  wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  initial begin
    if (WORDS < 2 || WIDTH < 1) $error("doau_data_ram: bad size");
  end
  logic [WIDTH-1:0] mem [WORDS];
  // Storage write
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // Registered read, one cycle latency
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// [src/doau_params.svh]
// Purpose: Constants for the operand address unit
// Assumes: Included by the package and design files
// Notes:   Offsets are word indices on the plain register port
`ifndef DOAU_PARAMS_SVH
`define DOAU_PARAMS_SVH
// ----------------------------------------
// Register port offsets
// ----------------------------------------
`define DOAU_REG_SYSCTL      4'h0
`define DOAU_REG_STATUS      4'h1
`define DOAU_REG_IDX0        4'h2
`define DOAU_REG_IDX1        4'h3
`define DOAU_REG_SECURE      4'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DOAU_SYSCTL_PMS_BIT  0
`define DOAU_STATUS_SEL_BIT  0
`define DOAU_STATUS_PAGE_BIT 1
`define DOAU_SECURE_BIT      0
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define DOAU_DATA_WORDS      256
`define DOAU_PROG_WORDS      4096
`define DOAU_RESERVED_TOP    96
`define DOAU_IO_PORTS        8
`define DOAU_IDX_RESET       16'h0000
`endif

// [src/doau_pkg.sv]
// Purpose: Types for the operand address unit
// Assumes: doau_params.svh holds the numbers
// Notes:   Types only
`include "doau_params.svh"
package doau_pkg;
  // Operand addressing modes
  typedef enum logic [1:0] {
    DOAU_MODE_DIRECT    = 2'b00,
    DOAU_MODE_INDIRECT  = 2'b01,
    DOAU_MODE_IMMEDIATE = 2'b10,
    DOAU_MODE_NONE      = 2'b11
  } doau_mode_type;
  // Index update requested by an indirect instruction
  typedef enum logic [1:0] {
    DOAU_UPD_HOLD = 2'b00,
    DOAU_UPD_INC  = 2'b01,
    DOAU_UPD_DEC  = 2'b10
  } doau_upd_type;
  // Instruction-side request bundle
  typedef struct packed {
    logic          valid;
    doau_mode_type mode;
    doau_upd_type  upd;
    logic [15:0]   word;
    logic          loop_branch;
    logic          load_index;
    logic          store_index;
    logic          index_sel_wr;
    logic          index_sel_val;
    logic          page_wr;
    logic          page_val;
  } doau_instr_type;
  // Program fetch request and answer
  typedef struct packed {
    logic        onchip;
    logic        offchip;
    logic        io_port;
    logic        blocked;
    logic [11:0] addr;
  } doau_fetch_type;
endpackage

// [src/doau_top.sv]
// Purpose: Operand address generation and program memory selection
// Assumes: One clock mclk at 200 MHz; sys_rst synchronous, active high
// Notes:   Memory mode pin is synchronised, then caught on reset release
//
// Operation
// - Keep a 256 by 16 data array apart from program storage.
// - Select bit one fetches on-chip, zero fetches off-chip.
// - Select bit loads from mode pin at reset, then software may write.
// - Switching the select bit at run time reaches up to 8K words.
// - Top eight external program words are I/O ports 0 to 7.
// - Once set, the security bit blocks reads of on-chip store.
// - On the mask variant the last 96 on-chip words are reserved.
// - Two 16-bit index registers, chosen by a status selector bit.
// - Auto count of an index register touches only its low nine bits.
// - Bits 9 to 15 never count; nine-bit field wraps both ways.
// - Store and load of an index register move all 16 bits.
// - Loop branch: nonzero index decrements and branches, else falls through.
// - Page bit chooses data page 0 (0-127) or page 1 (128-255).
// - Direct address is page bit above seven instruction bits.
// - Indirect address is low eight bits of the selected index.
// - Indirect count applies after the instruction, which uses the old value.
// - Immediate operand comes from the instruction word, no memory access.
// - Program path spans 4K words, data path spans 256 words.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "doau_params.svh"
module doau_top #(
  parameter int DATA_WORDS    = `DOAU_DATA_WORDS,
  parameter int PROG_WORDS    = `DOAU_PROG_WORDS,
  parameter int RESERVED_TOP  = `DOAU_RESERVED_TOP,
  parameter int IO_PORTS      = `DOAU_IO_PORTS,
  parameter bit MASK_VARIANT  = 1'b1
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // Mode strap pin
  input  wire logic                    interrupt_or_memory_mode_pin,
  // Register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  // Instruction side
  input  wire doau_pkg::doau_instr_type instr,
  input  wire logic [15:0]             store_data,
  // Operand side
  output logic      [7:0]              operand_addr,
  output logic                         operand_addr_valid,
  output logic      [15:0]             operand_value,
  output logic                         operand_imm_valid,
  output logic                         branch_taken,
  output logic                         branch_done,
  output logic      [15:0]             load_data,
  output logic                         load_valid,
  // Program fetch
  input  wire logic [12:0]             fetch_addr,
  input  wire logic                    fetch_req,
  output doau_pkg::doau_fetch_type     fetch_out,
  output logic                         program_memory_select
);
  import doau_pkg::*;

  initial begin
    if (DATA_WORDS != 256) $error("doau_top: data path is 8 bits wide");
    if (PROG_WORDS != 4096) $error("doau_top: program path is 12 bits wide");
    if (RESERVED_TOP >= PROG_WORDS || IO_PORTS < 1 || IO_PORTS > 256) begin
      $error("doau_top: bad reserved sizes");
    end
  end

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Nine-bit counting, upper seven bits left alone
  function automatic logic [15:0] idx_count(input logic [15:0] v, input doau_upd_type u);
    logic [8:0] low;
    low = v[8:0];
    unique case (u)
      DOAU_UPD_INC: low = low + 9'h001;
      DOAU_UPD_DEC: low = low - 9'h001;
      default:      low = v[8:0];
    endcase
    return {v[15:9], low};
  endfunction

  // Register decode used by the write paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // ----------------------------------------
  // Strap synchroniser
  // ----------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic rst_d;
  // Two flops before anything reads the pin
  always_ff @(posedge mclk) begin
    pin_meta <= interrupt_or_memory_mode_pin;
    pin_sync <= pin_meta;
  end
  // Reset history, used to catch the strap at release
  always_ff @(posedge mclk) begin
    rst_d <= sys_rst;
  end

  // ----------------------------------------
  // Program memory select and security
  // ----------------------------------------
  logic secure;
  logic strap_done;
  // Select is held low through reset and follows the pin for the first two cycles after it,
  // so the synchronised level is settled before software can write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      program_memory_select <= 1'b0;
      strap_done            <= 1'b0;
    end else if (!strap_done) begin
      program_memory_select <= pin_sync;
      strap_done            <= !rst_d;
    end else if (reg_wr && hit(reg_addr, `DOAU_REG_SYSCTL)) begin
      program_memory_select <= reg_wdata[`DOAU_SYSCTL_PMS_BIT];
    end
  end
  // Security latch: set only, cleared by reset alone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      secure <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `DOAU_REG_SECURE)
                 && reg_wdata[`DOAU_SECURE_BIT]) begin
      secure <= 1'b1;
    end
  end

  // ----------------------------------------
  // Program fetch steering
  // ----------------------------------------
  logic [11:0] fa;
  logic        io_hit;
  logic        rsv_hit;
  assign fa      = fetch_addr[11:0];
  assign io_hit  = fa >= 12'(PROG_WORDS - IO_PORTS);
  assign rsv_hit = MASK_VARIANT && (fa >= 12'(PROG_WORDS - RESERVED_TOP));
  // Fetch routing registered for the program memory side
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fetch_out <= '0;
    end else begin
      fetch_out.addr    <= fa;
      fetch_out.onchip  <= fetch_req && program_memory_select
                           && !secure && !rsv_hit;
      fetch_out.offchip <= fetch_req && !program_memory_select && !io_hit;
      fetch_out.io_port <= fetch_req && !program_memory_select && io_hit;
      fetch_out.blocked <= fetch_req && program_memory_select
                           && (secure || rsv_hit);
    end
  end

  // ----------------------------------------
  // Status bits and index registers
  // ----------------------------------------
  logic        index_reg_selector;
  logic        data_page_bit;
  logic [15:0] index_reg_zero;
  logic [15:0] index_reg_one;
  logic        next_sel;
  logic [15:0] cur_idx;
  logic        idx_nonzero;
  // Selector in force for this instruction, new value wins at once
  assign next_sel    = instr.index_sel_wr ? instr.index_sel_val : index_reg_selector;
  assign cur_idx     = next_sel ? index_reg_one : index_reg_zero;
  assign idx_nonzero = cur_idx != 16'h0000;
  // Status register bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      index_reg_selector <= 1'b0;
      data_page_bit      <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `DOAU_REG_STATUS)) begin
      index_reg_selector <= reg_wdata[`DOAU_STATUS_SEL_BIT];
      data_page_bit      <= reg_wdata[`DOAU_STATUS_PAGE_BIT];
    end else if (instr.valid) begin
      if (instr.index_sel_wr) index_reg_selector <= instr.index_sel_val;
      if (instr.page_wr)      data_page_bit      <= instr.page_val;
    end
  end

  // Pending load lands one cycle after the array read
  logic       load_pend;
  logic       load_sel;
  logic [15:0] ram_rd;
  // Index update: full loads, then post-instruction counting
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      index_reg_zero <= `DOAU_IDX_RESET;
      index_reg_one  <= `DOAU_IDX_RESET;
    end else begin
      if (reg_wr && hit(reg_addr, `DOAU_REG_IDX0)) index_reg_zero <= reg_wdata;
      else if (reg_wr && hit(reg_addr, `DOAU_REG_IDX1)) index_reg_one <= reg_wdata;
      else if (load_pend) begin
        if (load_sel) index_reg_one  <= ram_rd;
        else          index_reg_zero <= ram_rd;
      end else if (instr.valid && instr.loop_branch && idx_nonzero) begin
        if (next_sel) index_reg_one  <= idx_count(cur_idx, DOAU_UPD_DEC);
        else          index_reg_zero <= idx_count(cur_idx, DOAU_UPD_DEC);
      end else if (instr.valid && instr.mode == DOAU_MODE_INDIRECT) begin
        // Counting lands at the edge ending the instruction
        if (next_sel) index_reg_one  <= idx_count(cur_idx, instr.upd);
        else          index_reg_zero <= idx_count(cur_idx, instr.upd);
      end
    end
  end

  // ----------------------------------------
  // Operand address generation
  // ----------------------------------------
  logic [7:0] next_addr;
  always_comb begin
    unique case (instr.mode)
      DOAU_MODE_DIRECT:   next_addr = {data_page_bit, instr.word[6:0]};
      DOAU_MODE_INDIRECT: next_addr = cur_idx[7:0];
      default:            next_addr = 8'h00;
    endcase
  end
  // Registered operand outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      operand_addr       <= 8'h00;
      operand_addr_valid <= 1'b0;
      operand_value      <= 16'h0000;
      operand_imm_valid  <= 1'b0;
    end else begin
      operand_addr       <= next_addr;
      operand_addr_valid <= instr.valid && !instr.mode[1];
      operand_value      <= instr.word;
      operand_imm_valid  <= instr.valid && instr.mode == DOAU_MODE_IMMEDIATE;
    end
  end
  // Loop branch decision
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      branch_taken <= 1'b0;
      branch_done  <= 1'b0;
    end else begin
      branch_taken <= instr.valid && instr.loop_branch && idx_nonzero;
      branch_done  <= instr.valid && instr.loop_branch;
    end
  end

  // ----------------------------------------
  // Data array
  // ----------------------------------------
  logic       ram_wr;
  logic [7:0] ram_waddr;
  logic [15:0] ram_wdata;
  // Store of an index register moves the whole word
  assign ram_wr    = instr.valid && !instr.mode[1] && instr.store_index;
  assign ram_waddr = next_addr;
  assign ram_wdata = instr.store_index ? (index_reg_selector ? index_reg_one : index_reg_zero)
                                       : store_data;

  doau_data_ram #(
    .WORDS (DATA_WORDS),
    .WIDTH (16)
  ) u_ram (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wr_en   (ram_wr),
    .wr_addr (ram_waddr),
    .wr_data (ram_wdata),
    .rd_addr (next_addr),
    .rd_data (ram_rd)
  );

  // Load of an index register waits for the array read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      load_pend <= 1'b0;
      load_sel  <= 1'b0;
    end else begin
      load_pend <= instr.valid && instr.load_index && !instr.mode[1];
      load_sel  <= index_reg_selector;
    end
  end
  // Load result shown for one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      load_data  <= 16'h0000;
      load_valid <= 1'b0;
    end else begin
      load_data  <= ram_rd;
      load_valid <= load_pend;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DOAU_REG_SYSCTL: reg_rdata <= {15'h0000, program_memory_select};
        `DOAU_REG_STATUS: reg_rdata <= {14'h0000, data_page_bit, index_reg_selector};
        `DOAU_REG_IDX0:   reg_rdata <= index_reg_zero;
        `DOAU_REG_IDX1:   reg_rdata <= index_reg_one;
        `DOAU_REG_SECURE: reg_rdata <= {15'h0000, secure};
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [tb/doau_ext_mem.sv]
// Purpose: Off-chip program memory seen from the fetch side
// Assumes: Answers the cycle after an off-chip fetch
// Notes:   Word content is a pattern of the address
`timescale 1ns/1ps
`default_nettype none
module doau_ext_mem (
  // Clock
  input wire logic                     mclk,
  // Fetch side
  input wire doau_pkg::doau_fetch_type fetch_out,
  output logic [15:0]                  ext_word
);
  import doau_pkg::*;
  // ----------------------------------------
  // Memory answer
  // ----------------------------------------
  initial ext_word = 16'h0000;
  // Idle bus flips each cycle so a stale word never passes for an answer
  always @(posedge mclk) begin
    if (fetch_out.offchip) begin
      ext_word <= {4'h5, fetch_out.addr};
    end else begin
      ext_word <= ~ext_word;
    end
  end
endmodule
`default_nettype wire

// [tb/doau_sva.sv]
// Purpose: Port checks for the operand address unit
// Assumes: Bound to doau_top, one clock
// Notes:   Sees the top ports only
`timescale 1ns/1ps
`default_nettype none
`include "doau_params.svh"
module doau_sva #(
  parameter int PROG_WORDS   = 4096,
  parameter int RESERVED_TOP = 96,
  parameter int IO_PORTS     = 8
) (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     sys_rst,
  // Register port
  input wire logic [3:0]               reg_addr,
  input wire logic [15:0]              reg_wdata,
  input wire logic                     reg_wr,
  // Instruction and operand side
  input wire doau_pkg::doau_instr_type instr,
  input wire logic [7:0]               operand_addr,
  input wire logic                     operand_addr_valid,
  input wire logic [15:0]              operand_value,
  input wire logic                     operand_imm_valid,
  input wire logic                     branch_taken,
  input wire logic                     branch_done,
  input wire logic                     load_valid,
  // Fetch side
  input wire logic [12:0]              fetch_addr,
  input wire logic                     fetch_req,
  input wire doau_pkg::doau_fetch_type fetch_out,
  input wire logic                     program_memory_select
);
  import doau_pkg::*;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Bit 12 of the fetch address is ignored, so compare the low twelve only
  logic [11:0] fa;
  logic        sel;
  assign fa  = fetch_addr[11:0];
  assign sel = program_memory_select;
  // Page bit as software and instructions leave it; new value serves the next instruction
  logic page_model;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      page_model <= 1'b0;
    end else if (reg_wr && reg_addr == `DOAU_REG_STATUS) begin
      page_model <= reg_wdata[`DOAU_STATUS_PAGE_BIT];
    end else if (instr.valid && instr.page_wr) begin
      page_model <= instr.page_val;
    end
  end
  a_onchip_sel: assert property (fetch_req && sel |=> !fetch_out.offchip && !fetch_out.io_port)
    else $error("on-chip fetch went off-chip");
  a_offchip_sel: assert property (fetch_req && !sel && fa < PROG_WORDS - IO_PORTS
    |=> fetch_out.offchip && !fetch_out.onchip) else $error("off-chip fetch wrong");
  a_io_top: assert property (fetch_req && !sel && fa >= PROG_WORDS - IO_PORTS
    |=> fetch_out.io_port && !fetch_out.offchip) else $error("top words not I/O");
  a_reserved_top: assert property (fetch_req && sel && fa >= PROG_WORDS - RESERVED_TOP
    |=> fetch_out.blocked && !fetch_out.onchip) else $error("reserved word fetched");
  a_fetch_span: assert property (fetch_req |=> fetch_out.addr == $past(fa))
    else $error("fetch address wrong");
  a_direct_form: assert property (instr.valid && instr.mode == DOAU_MODE_DIRECT
    |=> operand_addr_valid && operand_addr == {$past(page_model), $past(instr.word[6:0])})
    else $error("direct address wrong");
  a_imm_field: assert property (instr.valid && instr.mode == DOAU_MODE_IMMEDIATE
    |=> operand_imm_valid && !operand_addr_valid && operand_value == $past(instr.word))
    else $error("immediate operand wrong");
  a_loop_done: assert property (instr.valid && instr.loop_branch |=> branch_done)
    else $error("loop branch not answered");
  a_branch_cause: assert property (branch_taken |-> branch_done && $past(instr.loop_branch))
    else $error("branch without loop instruction");
  a_load_lat: assert property (instr.valid && instr.load_index
    && instr.mode inside {DOAU_MODE_DIRECT, DOAU_MODE_INDIRECT} |-> ##2 load_valid)
    else $error("index load late");
  c_branch: cover property (branch_taken);
  c_io: cover property (fetch_out.io_port);
  c_load: cover property (load_valid);
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the operand address unit
// Assumes: Strap pin high through reset
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
`include "doau_params.svh"
module tb;
  import doau_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic           mclk, sys_rst, pin, reg_wr, reg_rd, fetch_req;
  logic [3:0]     reg_addr;
  logic [15:0]    reg_wdata, store_data, rd_val, reg_rdata, operand_value, load_data, ext_word;
  logic [12:0]    fetch_addr;
  logic [7:0]     operand_addr;
  logic           op_v, imm_v, br_t, br_d, load_valid, pms;
  doau_instr_type instr;
  doau_fetch_type fetch_out;
  int             bad_count, total_checks, cycles;
  doau_top dut (.mclk(mclk), .sys_rst(sys_rst), .interrupt_or_memory_mode_pin(pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr(instr), .store_data(store_data),
    .operand_addr(operand_addr), .operand_addr_valid(op_v), .operand_value(operand_value),
    .operand_imm_valid(imm_v), .branch_taken(br_t), .branch_done(br_d),
    .load_data(load_data), .load_valid(load_valid), .fetch_addr(fetch_addr),
    .fetch_req(fetch_req), .fetch_out(fetch_out), .program_memory_select(pms));
  doau_ext_mem u_mem (.mclk(mclk), .fetch_out(fetch_out), .ext_word(ext_word));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic issue(input doau_instr_type i);
    @(posedge mclk);
    instr <= i;
    @(posedge mclk);
    instr <= '0;
    #1;
  endtask
  // Flags in order onchip, offchip, io_port, blocked
  task automatic fch(input logic [12:0] a, input logic [3:0] exp);
    @(posedge mclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge mclk);
    fetch_req <= 1'b0;
    #1 chk("fetch flags", {12'h000, fetch_out[15:12]}, {12'h000, exp});
    chk("fetch addr", {4'h0, fetch_out.addr}, {4'h0, a[11:0]});
  endtask
  // Flags: loop, load, store, sel_wr, sel_val, page_wr, page_val
  function automatic doau_instr_type mk(doau_mode_type m, doau_upd_type u, logic [15:0] w,
    logic [6:0] f);
    mk = {1'b1, m, u, w, f};
  endfunction
  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Whole sequence needs under a hundred cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {sys_rst, pin, reg_wr, reg_rd, fetch_req} = 5'b11000;
    {reg_addr, reg_wdata, store_data, fetch_addr} = '0;
    instr = '0;
    {bad_count, total_checks, cycles} = '0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    pin <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk("select strap", {15'h0, pms}, 16'h0001);
    rd(`DOAU_REG_SYSCTL);
    chk("sysctl", rd_val, 16'h0001);
    fch(13'h0064, 4'b1000);
    fch(13'h0F9F, 4'b1000);
    fch(13'h0FA0, 4'b0001);
    wr(`DOAU_REG_SYSCTL, 16'h0000);
    chk("select write", {15'h0, pms}, 16'h0000);
    fch(13'h0064, 4'b0100);
    @(posedge mclk);
    #1 chk("external word", ext_word, 16'h5064);
    fch(13'h0FF7, 4'b0100);
    fch(13'h1FF8, 4'b0010);
    rd(4'hF);
    chk("unmapped", rd_val, 16'h0000);
    wr(`DOAU_REG_IDX0, 16'hFFFF);
    issue(mk(DOAU_MODE_INDIRECT, DOAU_UPD_INC, 16'h0000, 7'b0001000));
    chk("indirect addr", {8'h00, operand_addr}, 16'h00FF);
    chk("addr valid", {15'h0, op_v}, 16'h0001);
    rd(`DOAU_REG_IDX0);
    chk("inc wrap", rd_val, 16'hFE00);
    wr(`DOAU_REG_IDX1, 16'hAA00);
    issue(mk(DOAU_MODE_INDIRECT, DOAU_UPD_DEC, 16'h0000, 7'b0001100));
    chk("new selector", {8'h00, operand_addr}, 16'h0000);
    rd(`DOAU_REG_IDX1);
    chk("dec wrap", rd_val, 16'hABFF);
    rd(`DOAU_REG_IDX0);
    chk("other index", rd_val, 16'hFE00);
    issue(mk(DOAU_MODE_DIRECT, DOAU_UPD_HOLD, 16'hFF05, 7'b0000010));
    chk("page zero", {8'h00, operand_addr}, 16'h0005);
    // A page written by an instruction serves the next one
    issue(mk(DOAU_MODE_DIRECT, DOAU_UPD_HOLD, 16'h0005, 7'b0000011));
    chk("page kept", {8'h00, operand_addr}, 16'h0005);
    issue(mk(DOAU_MODE_DIRECT, DOAU_UPD_HOLD, 16'h0005, 7'b0000000));
    chk("page one", {8'h00, operand_addr}, 16'h0085);
    rd(`DOAU_REG_STATUS);
    chk("status", rd_val, 16'h0003);
    issue(mk(DOAU_MODE_IMMEDIATE, DOAU_UPD_HOLD, 16'h1234, 7'b0000000));
    chk("immediate", operand_value, 16'h1234);
    chk("imm valid", {15'h0, imm_v}, 16'h0001);
    issue(mk(DOAU_MODE_NONE, DOAU_UPD_HOLD, 16'h0000, 7'b1000000));
    chk("loop taken", {14'h0, br_t, br_d}, 16'h0003);
    rd(`DOAU_REG_IDX1);
    chk("loop count", rd_val, 16'hABFE);
    wr(`DOAU_REG_IDX1, 16'h0000);
    issue(mk(DOAU_MODE_NONE, DOAU_UPD_HOLD, 16'h0000, 7'b1000000));
    chk("loop falls", {14'h0, br_t, br_d}, 16'h0001);
    rd(`DOAU_REG_IDX1);
    chk("zero kept", rd_val, 16'h0000);
    wr(`DOAU_REG_IDX1, 16'h8123);
    issue(mk(DOAU_MODE_DIRECT, DOAU_UPD_HOLD, 16'h0010, 7'b0010000));
    issue(mk(DOAU_MODE_NONE, DOAU_UPD_HOLD, 16'h0000, 7'b0001000));
    issue(mk(DOAU_MODE_DIRECT, DOAU_UPD_HOLD, 16'h0010, 7'b0100000));
    @(posedge mclk);
    #1 chk("load data", load_data, 16'h8123);
    chk("load valid", {15'h0, load_valid}, 16'h0001);
    rd(`DOAU_REG_IDX0);
    chk("index loaded", rd_val, 16'h8123);
    wr(`DOAU_REG_SYSCTL, 16'h0001);
    wr(`DOAU_REG_SECURE, 16'h0001);
    fch(13'h0064, 4'b0001);
    stop_test();
  end
endmodule
bind doau_top doau_sva #(.PROG_WORDS(PROG_WORDS), .RESERVED_TOP(RESERVED_TOP),
  .IO_PORTS(IO_PORTS)) u_sva (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .instr(instr),
  .operand_addr(operand_addr), .operand_addr_valid(operand_addr_valid),
  .operand_value(operand_value), .operand_imm_valid(operand_imm_valid),
  .branch_taken(branch_taken), .branch_done(branch_done), .load_valid(load_valid),
  .fetch_addr(fetch_addr), .fetch_req(fetch_req), .fetch_out(fetch_out),
  .program_memory_select(program_memory_select));
`default_nettype wire
